// file: clk_ctrl_pkg.sv
// Constants shared by the clock control register block.
package clk_ctrl_pkg;
    localparam int          CLK_NS       = 8;
    localparam int          ADDR_W       = 12;
    localparam int          DEB_UNIT_NS  = 1000;
    localparam int          DEB_CYC      = (DEB_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CAL_NS       = 16000;
    localparam int          CAL_CYC      = (CAL_NS + CLK_NS - 1) / CLK_NS;
    // Task registers.
    localparam logic [11:0] OFS_HF_START = 12'h000;
    localparam logic [11:0] OFS_HF_STOP  = 12'h004;
    localparam logic [11:0] OFS_LF_START = 12'h008;
    localparam logic [11:0] OFS_LF_STOP  = 12'h00c;
    localparam logic [11:0] OFS_CAL      = 12'h010;
    localparam logic [11:0] OFS_CT_START = 12'h014;
    localparam logic [11:0] OFS_CT_STOP  = 12'h018;
    // Event registers.
    localparam logic [11:0] OFS_EV_HF    = 12'h100;
    localparam logic [11:0] OFS_EV_LF    = 12'h104;
    localparam logic [11:0] OFS_EV_DONE  = 12'h10c;
    localparam logic [11:0] OFS_EV_CAL_TIMER_TIMEOUT_EVENT  = 12'h110;
    localparam logic [11:0] OFS_EV_CTSTA = 12'h128;
    localparam logic [11:0] OFS_EV_CTSTO = 12'h12c;
    // Control and status registers.
    localparam logic [11:0] OFS_IEN_SET  = 12'h304;
    localparam logic [11:0] OFS_IEN_CLR  = 12'h308;
    localparam logic [11:0] OFS_HF_RUN   = 12'h408;
    localparam logic [11:0] OFS_HF_STAT  = 12'h40c;
    localparam logic [11:0] OFS_LF_RUN   = 12'h414;
    localparam logic [11:0] OFS_LF_STAT  = 12'h418;
    localparam logic [11:0] OFS_SRC_COPY = 12'h41c;
    localparam logic [11:0] OFS_SRC_SEL  = 12'h518;
    localparam logic [11:0] OFS_DEBOUNCE = 12'h528;
    localparam logic [11:0] OFS_CAL_TIMER_INTERVAL     = 12'h538;
    localparam logic [11:0] OFS_TRACE    = 12'h55c;
    localparam logic [11:0] OFS_RC_MODE  = 12'h5b4;
    // Event index, also the interrupt enable bit position.
    localparam int          EV_HF        = 0;
    localparam int          EV_LF        = 1;
    localparam int          EV_DONE      = 2;
    localparam int          EV_CAL_TIMER_TIMEOUT_EVENT      = 3;
    localparam int          EV_CTSTA     = 4;
    localparam int          EV_CTSTO     = 5;
    localparam int          NUM_EV       = 6;
    // Field positions.
    localparam int          STATE_BIT    = 16;
    localparam int          BYPASS_BIT   = 16;
    localparam int          EXT_BIT      = 17;
    // Reset values and field masks.
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] SRC_SEL_MASK = 32'h0003_0003;
    localparam logic [31:0] DEB_MASK     = 32'h0000_00ff;
    localparam logic [31:0] CAL_TIMER_INTERVAL_MASK    = 32'h0000_007f;
    localparam logic [31:0] TRACE_MASK   = 32'h0003_0003;
    localparam logic [31:0] RC_MODE_MASK = 32'h0000_0001;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    typedef enum logic [1:0] {OSC_OFF, OSC_STARTING, OSC_ON} osc_state_t;
endpackage

// file: clk_ctrl.sv
// Clock control task, event and status registers behind an AXI4-Lite slave.
//
// Notes on behaviour
// - Start task write starts fast crystal oscillator.
// - Stop task write stops fast crystal oscillator.
// - Calibrate task begins slow RC calibration run.
// - Timer start task starts calibration timer.
// - Timer stop task stops calibration timer.
// - Fast run request shows start task triggered.
// - Slow run request shows start task triggered.
// - Slow start captures source selection snapshot.
// - Fast started event reads one after start.
// - Done event set when calibration completes.
// - Timer started event set, tasks accepted again.
// - Timer stopped event set, tasks accepted again.
// - Enable set: ones enable, reads enable state.
// - Enable clear: ones disable, reads enable state.
// - Timer ignores tasks until matching event raised.
// - Timer counts down, times out, stops itself.
// - Fast started event waits power-up plus debounce.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module clk_ctrl #(
    parameter int PWRUP_NS    = 50000,
    parameter int LF_START_NS = 1000000,
    parameter int CT_TICK_CYC = 1000
) (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write address and data
    input  wire logic [clk_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read
    input  wire logic [clk_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Oscillator controls and interrupt
    output logic                            fast_osc_enable,
    output logic                            slow_clock_enable,
    output logic [1:0]                      slow_clock_source,
    output logic                            irq
);
    import clk_ctrl_pkg::*;

    localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int LF_CYC    = (LF_START_NS + CLK_NS - 1) / CLK_NS;

    ////////////////////////////////////////////////////////////////////////
    // Address map check, shared by the write and read paths.
    function automatic logic mapped(input logic [11:0] a);
        unique case (a)
            OFS_HF_START, OFS_HF_STOP, OFS_LF_START, OFS_LF_STOP, OFS_CAL,
            OFS_CT_START, OFS_CT_STOP, OFS_EV_HF, OFS_EV_LF, OFS_EV_DONE,
            OFS_EV_CAL_TIMER_TIMEOUT_EVENT, OFS_EV_CTSTA, OFS_EV_CTSTO, OFS_IEN_SET,
            OFS_IEN_CLR, OFS_HF_RUN, OFS_HF_STAT, OFS_LF_RUN, OFS_LF_STAT,
            OFS_SRC_COPY, OFS_SRC_SEL, OFS_DEBOUNCE, OFS_CAL_TIMER_INTERVAL, OFS_TRACE,
            OFS_RC_MODE: mapped = 1'b1;
            default:     mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb,
                                          input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        merge = r & mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are held separately, in any order.
    logic [11:0] awaddr_q;
    logic        aw_full_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_full_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        wr_go;
    logic        task1;

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready  = !w_full_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign wr_go = aw_full_q && w_full_q && !bvalid_q;
    // A task fires only on a write of 1 into bit 0 with its lane enabled.
    assign task1 = wr_go && wstrb_q[0] && wdata_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end else if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q  <= RST_ZERO;
            wstrb_q  <= 4'h0;
        end else if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_go) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    function automatic logic hit(input logic [11:0] ofs);
        hit = wr_go && (awaddr_q == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    logic [31:0] src_sel_q;
    logic [31:0] debounce_q;
    logic [31:0] cal_timer_interval_q;
    logic [31:0] trace_q;
    logic [31:0] rc_mode_q;
    logic [31:0] src_copy_q;
    logic [NUM_EV-1:0] ien_q;
    osc_state_t  hf_q;
    osc_state_t  lf_q;

    // Source selection is frozen while the slow clock runs, and the debounce
    // value while the fast oscillator starts, so a running count never sees
    // its setting change underneath it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_sel_q  <= RST_ZERO;
            debounce_q <= RST_ZERO;
            cal_timer_interval_q     <= RST_ZERO;
            trace_q    <= RST_ZERO;
            rc_mode_q  <= RST_ZERO;
        end else begin
            if (hit(OFS_SRC_SEL) && lf_q == OSC_OFF) begin
                src_sel_q <= merge(src_sel_q, wdata_q, wstrb_q, SRC_SEL_MASK);
            end
            if (hit(OFS_DEBOUNCE) && hf_q != OSC_STARTING) begin
                debounce_q <= merge(debounce_q, wdata_q, wstrb_q, DEB_MASK);
            end
            if (hit(OFS_CAL_TIMER_INTERVAL)) begin
                cal_timer_interval_q <= merge(cal_timer_interval_q, wdata_q, wstrb_q, CAL_TIMER_INTERVAL_MASK);
            end
            if (hit(OFS_TRACE)) begin
                trace_q <= merge(trace_q, wdata_q, wstrb_q, TRACE_MASK);
            end
            if (hit(OFS_RC_MODE)) begin
                rc_mode_q <= merge(rc_mode_q, wdata_q, wstrb_q, RC_MODE_MASK);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_q <= '0;
        end else if (hit(OFS_IEN_SET) && wstrb_q[0]) begin
            ien_q <= ien_q | wdata_q[NUM_EV-1:0];
        end else if (hit(OFS_IEN_CLR) && wstrb_q[0]) begin
            ien_q <= ien_q & ~wdata_q[NUM_EV-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fast crystal oscillator start sequence.
    logic [31:0] hf_cnt_q;
    logic        hf_run_q;
    logic [NUM_EV-1:0] ev_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hf_q     <= OSC_OFF;
            hf_cnt_q <= RST_ZERO;
        end else if (task1 && awaddr_q == OFS_HF_STOP) begin
            hf_q <= OSC_OFF;
        end else if (task1 && awaddr_q == OFS_HF_START && hf_q == OSC_OFF) begin
            hf_q     <= OSC_STARTING;
            hf_cnt_q <= 32'(PWRUP_CYC) + 32'(debounce_q[7:0] * DEB_CYC);
        end else if (hf_q == OSC_STARTING) begin
            if (hf_cnt_q <= 32'h0000_0001) begin
                hf_q <= OSC_ON;
            end
            hf_cnt_q <= hf_cnt_q - 32'h0000_0001;
        end
    end
    assign ev_set[EV_HF] = hf_q == OSC_STARTING &&
                           hf_cnt_q <= 32'h0000_0001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hf_run_q <= 1'b0;
        end else if (task1 && awaddr_q == OFS_HF_START) begin
            hf_run_q <= 1'b1;
        end else if (task1 && awaddr_q == OFS_HF_STOP) begin
            hf_run_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow clock start sequence and source snapshot.
    logic [31:0] lf_cnt_q;
    logic        lf_run_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf_q     <= OSC_OFF;
            lf_cnt_q <= RST_ZERO;
        end else if (task1 && awaddr_q == OFS_LF_STOP) begin
            lf_q <= OSC_OFF;
        end else if (task1 && awaddr_q == OFS_LF_START && lf_q == OSC_OFF) begin
            lf_q     <= OSC_STARTING;
            lf_cnt_q <= 32'(LF_CYC);
        end else if (lf_q == OSC_STARTING) begin
            if (lf_cnt_q <= 32'h0000_0001) begin
                lf_q <= OSC_ON;
            end
            lf_cnt_q <= lf_cnt_q - 32'h0000_0001;
        end
    end
    assign ev_set[EV_LF] = lf_q == OSC_STARTING &&
                           lf_cnt_q <= 32'h0000_0001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf_run_q   <= 1'b0;
            src_copy_q <= RST_ZERO;
        end else if (task1 && awaddr_q == OFS_LF_START) begin
            lf_run_q   <= 1'b1;
            src_copy_q <= {30'h0, src_sel_q[1:0]};
        end else if (task1 && awaddr_q == OFS_LF_STOP) begin
            lf_run_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration of the slow RC oscillator. The run needs the fast
    // oscillator as reference, so it waits while that is not running.
    logic        cal_pend_q;
    logic [31:0] cal_cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_pend_q <= 1'b0;
            cal_cnt_q  <= RST_ZERO;
        end else if (task1 && awaddr_q == OFS_CAL && !cal_pend_q) begin
            cal_pend_q <= 1'b1;
            cal_cnt_q  <= 32'(CAL_CYC);
        end else if (cal_pend_q && hf_q == OSC_ON) begin
            if (cal_cnt_q <= 32'h0000_0001) begin
                cal_pend_q <= 1'b0;
            end
            cal_cnt_q <= cal_cnt_q - 32'h0000_0001;
        end
    end
    assign ev_set[EV_DONE] = cal_pend_q && hf_q == OSC_ON &&
                             cal_cnt_q <= 32'h0000_0001;

    ////////////////////////////////////////////////////////////////////////
    // Calibration timer. A start or stop task is answered by its event one
    // cycle later; during that cycle further tasks are dropped.
    logic        ct_run_q;
    logic [6:0]  ct_cnt_q;
    logic [31:0] ct_tick_q;
    logic        ct_sta_q;
    logic        ct_sto_q;
    logic        ct_busy;
    logic        ct_start;
    logic        ct_stop;
    logic        ct_tick;

    assign ct_busy  = ct_sta_q || ct_sto_q;
    assign ct_start = task1 && awaddr_q == OFS_CT_START && !ct_busy;
    assign ct_stop  = task1 && awaddr_q == OFS_CT_STOP && !ct_busy;
    assign ct_tick  = ct_tick_q >= 32'(CT_TICK_CYC - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ct_sta_q <= 1'b0;
            ct_sto_q <= 1'b0;
        end else begin
            ct_sta_q <= ct_start;
            ct_sto_q <= ct_stop;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ct_run_q  <= 1'b0;
            ct_cnt_q  <= 7'h00;
            ct_tick_q <= RST_ZERO;
        end else if (ct_stop) begin
            ct_run_q <= 1'b0;
        end else if (ct_start && !ct_run_q) begin
            ct_run_q  <= 1'b1;
            ct_cnt_q  <= cal_timer_interval_q[6:0];
            ct_tick_q <= RST_ZERO;
        end else if (ct_run_q) begin
            if (ct_cnt_q == 7'h00) begin
                ct_run_q <= 1'b0;
            end else if (ct_tick) begin
                ct_cnt_q  <= ct_cnt_q - 7'h01;
                ct_tick_q <= RST_ZERO;
            end else begin
                ct_tick_q <= ct_tick_q + 32'h0000_0001;
            end
        end
    end
    assign ev_set[EV_CAL_TIMER_TIMEOUT_EVENT]  = ct_run_q && ct_cnt_q == 7'h00 && !ct_stop;
    assign ev_set[EV_CTSTA] = ct_sta_q;
    assign ev_set[EV_CTSTO] = ct_sto_q;

    ////////////////////////////////////////////////////////////////////////
    // Event flags: software writes the stored value, a hardware set wins.
    localparam logic [11:0] EV_OFS [NUM_EV] = '{OFS_EV_HF, OFS_EV_LF,
        OFS_EV_DONE, OFS_EV_CAL_TIMER_TIMEOUT_EVENT, OFS_EV_CTSTA, OFS_EV_CTSTO};
    logic [NUM_EV-1:0] ev_q;

    for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ev_q[i] <= 1'b0;
            end else if (ev_set[i]) begin
                ev_q[i] <= 1'b1;
            end else if (hit(EV_OFS[i]) && wstrb_q[0]) begin
                ev_q[i] <= wdata_q[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_q & ien_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_osc_enable   <= 1'b0;
            slow_clock_enable <= 1'b0;
            slow_clock_source <= 2'h0;
        end else begin
            fast_osc_enable   <= hf_q != OSC_OFF;
            slow_clock_enable <= lf_q != OSC_OFF;
            slow_clock_source <= src_copy_q[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel. Task registers read as zero.
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd;
    logic [11:0] ra;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign ra = s_axi_araddr;

    always_comb begin
        rd = RST_ZERO;
        unique case (ra)
            OFS_EV_HF:    rd = {31'h0, ev_q[EV_HF]};
            OFS_EV_LF:    rd = {31'h0, ev_q[EV_LF]};
            OFS_EV_DONE:  rd = {31'h0, ev_q[EV_DONE]};
            OFS_EV_CAL_TIMER_TIMEOUT_EVENT:  rd = {31'h0, ev_q[EV_CAL_TIMER_TIMEOUT_EVENT]};
            OFS_EV_CTSTA: rd = {31'h0, ev_q[EV_CTSTA]};
            OFS_EV_CTSTO: rd = {31'h0, ev_q[EV_CTSTO]};
            OFS_IEN_SET,
            OFS_IEN_CLR:  rd = {26'h0, ien_q};
            OFS_HF_RUN:   rd = {31'h0, hf_run_q};
            OFS_LF_RUN:   rd = {31'h0, lf_run_q};
            OFS_SRC_COPY: rd = src_copy_q;
            OFS_SRC_SEL:  rd = src_sel_q;
            OFS_DEBOUNCE: rd = debounce_q;
            OFS_CAL_TIMER_INTERVAL:     rd = cal_timer_interval_q;
            OFS_TRACE:    rd = trace_q;
            OFS_RC_MODE:  rd = rc_mode_q;
            OFS_HF_STAT: begin
                rd[0]         = hf_q == OSC_ON;
                rd[STATE_BIT] = hf_q == OSC_ON;
            end
            OFS_LF_STAT: begin
                rd[1:0]       = src_copy_q[1:0];
                rd[STATE_BIT] = lf_q == OSC_ON;
            end
            default:      rd = RST_ZERO;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= RST_ZERO;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd;
            rresp_q  <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule

// file: clk_ctrl_props.sv
// Port-level assertions for the clock control register block.
`timescale 1ns/1ps
module clk_ctrl_props (
    // Clock and reset
    input wire logic                            aclk,
    input wire logic                            aresetn,
    // Register bus
    input wire logic [clk_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic                            s_axi_awvalid,
    input wire logic                            s_axi_awready,
    input wire logic [31:0]                     s_axi_wdata,
    input wire logic [3:0]                      s_axi_wstrb,
    input wire logic                            s_axi_wvalid,
    input wire logic                            s_axi_wready,
    input wire logic                            s_axi_bvalid,
    input wire logic [clk_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                            s_axi_arvalid,
    input wire logic                            s_axi_arready,
    input wire logic [31:0]                     s_axi_rdata,
    input wire logic [1:0]                      s_axi_rresp,
    input wire logic                            s_axi_rvalid,
    // Clock controls and interrupt
    input wire logic                            fast_osc_enable,
    input wire logic                            slow_clock_enable,
    input wire logic                            irq
);
    import clk_ctrl_pkg::*;
    logic wr_go;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A committed trigger write: both halves taken, nothing pending.
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                   s_axi_wready && !s_axi_bvalid && s_axi_wstrb[0] &&
                   s_axi_wdata[0];
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready
        |-> ##[1:4] s_axi_bvalid) else $error("write response missing");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read response missing");
    rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 12'h0fc |=> s_axi_rresp == RESP_SLVERR &&
        s_axi_rdata == RST_ZERO) else $error("unmapped read not refused");
    fast_start_a: assert property (wr_go && s_axi_awaddr == OFS_HF_START
        |-> ##[2:3] fast_osc_enable) else $error("fast osc not started");
    fast_stop_a: assert property (wr_go && s_axi_awaddr == OFS_HF_STOP
        |-> ##[2:3] !fast_osc_enable) else $error("fast osc not stopped");
    slow_start_a: assert property (wr_go && s_axi_awaddr == OFS_LF_START
        |-> ##[2:3] slow_clock_enable) else $error("slow clock not started");
    slow_stop_a: assert property (wr_go && s_axi_awaddr == OFS_LF_STOP
        |-> ##[2:3] !slow_clock_enable) else $error("slow clock not stopped");
    irq_off_a: assert property (wr_go && s_axi_awaddr == OFS_IEN_CLR &&
        s_axi_wdata[5:0] == 6'h3f |-> ##[3:4] !irq)
        else $error("irq high with all enables cleared");
    reset_quiet_a: assert property (disable iff (1'b0) !aresetn
        |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !fast_osc_enable)
        else $error("outputs active after reset");
endmodule
bind clk_ctrl clk_ctrl_props i_props (.*);

// file: clk_ctrl_tb.sv
// Self-checking bench for the clock control register block.
`timescale 1ns/1ps
module clk_ctrl_tb;
    import clk_ctrl_pkg::*;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, lf_src;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, hf_en, lf_en, irq;
    int          err_total = 0;
    int          checks = 0;
    // Short start-up times keep the run brief: ten cycles of power-up.
    clk_ctrl #(.PWRUP_NS(80), .LF_START_NS(80), .CT_TICK_CYC(4)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fast_osc_enable(hf_en),
        .slow_clock_enable(lf_en), .slow_clock_source(lf_src), .irq(irq));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, r});
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                       input logic [31:0] m);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata & m, e);
    endtask
    // The pin is passed by reference so that it is sampled after the wait.
    task automatic pin(ref logic v, input logic e);
        repeat (2) @(negedge aclk);
        chk({31'h0, v}, {31'h0, e});
    endtask
    task automatic stop_test;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // The whole sequence needs about 2500 cycles.
    initial begin
        #(8 * 20000);
        err_total++;
        stop_test();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(OFS_IEN_SET, 32'h0, 32'hffff_ffff);
        rdc(OFS_HF_RUN, 32'h0, 32'h1);
        rdc(12'h0fc, 32'h0, 32'hffff_ffff);
        wr(12'h020, 32'h1, RESP_SLVERR);
        wr(OFS_IEN_SET, 32'h3f, RESP_OKAY);
        wr(OFS_IEN_SET, 32'h0, RESP_OKAY);
        wr(OFS_IEN_CLR, 32'h3e, RESP_OKAY);
        rdc(OFS_IEN_CLR, 32'h1, 32'h3f);
        rdc(OFS_IEN_SET, 32'h1, 32'h3f);
        // One debounce unit adds 125 cycles to the ten of power-up.
        wr(OFS_DEBOUNCE, 32'h1, RESP_OKAY);
        wr(OFS_HF_START, 32'h1, RESP_OKAY);
        pin(hf_en, 1'b1);
        rdc(OFS_HF_RUN, 32'h1, 32'h1);
        repeat (100) @(posedge aclk);
        rdc(OFS_EV_HF, 32'h0, 32'h1);
        pin(irq, 1'b0);
        repeat (40) @(posedge aclk);
        rdc(OFS_EV_HF, 32'h1, 32'h1);
        pin(irq, 1'b1);
        rdc(OFS_HF_STAT, 32'h0001_0001, 32'hffff_ffff);
        wr(OFS_EV_HF, 32'h0, RESP_OKAY);
        pin(irq, 1'b0);
        wr(OFS_CAL, 32'h1, RESP_OKAY);
        repeat (CAL_CYC - 100) @(posedge aclk);
        rdc(OFS_EV_DONE, 32'h0, 32'h1);
        repeat (150) @(posedge aclk);
        rdc(OFS_EV_DONE, 32'h1, 32'h1);
        wr(OFS_HF_STOP, 32'h1, RESP_OKAY);
        pin(hf_en, 1'b0);
        rdc(OFS_HF_RUN, 32'h0, 32'h1);
        wr(OFS_SRC_SEL, 32'h2, RESP_OKAY);
        wr(OFS_LF_START, 32'h1, RESP_OKAY);
        rdc(OFS_LF_RUN, 32'h1, 32'h1);
        rdc(OFS_SRC_COPY, 32'h2, 32'h3);
        wr(OFS_SRC_SEL, 32'h1, RESP_OKAY);
        repeat (30) @(posedge aclk);
        rdc(OFS_EV_LF, 32'h1, 32'h1);
        rdc(OFS_SRC_SEL, 32'h2, 32'h3);
        rdc(OFS_LF_STAT, 32'h0001_0002, 32'hffff_ffff);
        chk({30'h0, lf_src}, 32'h2);
        pin(lf_en, 1'b1);
        wr(OFS_LF_STOP, 32'h1, RESP_OKAY);
        pin(lf_en, 1'b0);
        wr(OFS_CAL_TIMER_INTERVAL, 32'h3, RESP_OKAY);
        wr(OFS_CT_START, 32'h1, RESP_OKAY);
        rdc(OFS_EV_CTSTA, 32'h1, 32'h1);
        rdc(OFS_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h0, 32'h1);
        repeat (20) @(posedge aclk);
        rdc(OFS_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h1, 32'h1);
        wr(OFS_CT_START, 32'h1, RESP_OKAY);
        wr(OFS_CT_STOP, 32'h1, RESP_OKAY);
        rdc(OFS_EV_CTSTO, 32'h1, 32'h1);
        wr(OFS_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h0, RESP_OKAY);
        repeat (30) @(posedge aclk);
        rdc(OFS_EV_CAL_TIMER_TIMEOUT_EVENT, 32'h0, 32'h1);
        wr(OFS_IEN_CLR, 32'h3f, RESP_OKAY);
        rdc(OFS_IEN_SET, 32'h0, 32'h3f);
        stop_test();
    end
endmodule
